// ==== logic/link_setup.sv ====
// Top of the link-setup block.
// Assumes pin-level line indications and straps from outside the clock domain.
`timescale 1ns/1ps
`include "link_setup_consts.svh"

module link_setup #(
  parameter int PD_LIMIT_CYC    = `PD_LIMIT_CYC,
  parameter int XOVER_DWELL_CYC = `XOVER_DWELL_CYC
) (
  input  wire logic       CLK,
  input  wire logic       SYS_RST,
  input  wire logic       ANEG_EN,
  input  wire logic       SPEED_LSB,
  input  wire logic       SPEED_MSB,
  input  wire logic       FULL_DUPLEX,
  input  wire logic       XOVER_EN,
  input  wire logic       POL_EN,
  input  wire logic       XOVER_FORCED_OK_N,
  input  wire logic [1:0] XOVER_FORCE,
  input  wire logic       TX10_REDUCED,
  input  wire logic       PD_EN,
  input  wire logic       PD_IRQ_READ,
  input  wire logic       TX_IDLE,
  input  wire logic [1:0] REF_CLOCK_MODE_SELECT,
  input  wire logic       LINE_ENERGY,
  input  wire logic       LINE_FLP_SEEN,
  input  wire logic       LINE_FLP_ECHO,
  input  wire logic       LINE_LINK_GOOD,
  input  wire logic       LINE_POL_BAD_A,
  input  wire logic       LINE_POL_BAD_B,
  output logic            ANEG_ACTIVE,
  output logic [1:0]      SPEED,
  output logic            DUPLEX_FULL,
  output logic            PARALLEL_DETECTED,
  output logic            CROSSED,
  output logic            POL_INV_A,
  output logic            POL_INV_B,
  output logic            LPI_ACTIVE,
  output logic            TX10_LOW_AMP,
  output logic [1:0]      CLK_MODE,
  output logic            OSC_ON,
  output logic            PD_SEARCHING,
  output logic [1:0]      PD_STATUS,
  output logic            PD_IRQ,
  output logic            LINK_STATUS
);

  // --------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------
  initial begin
    if (PD_LIMIT_CYC < 1) $error("link_setup: PD_LIMIT_CYC below one");
    if (XOVER_DWELL_CYC < 1) $error("link_setup: XOVER_DWELL_CYC below one");
  end

  // --------------------------------------------------------------------
  // State record
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [5:0]                    line_s1;
    logic [5:0]                    line_s2;
    logic [5:0]                    line_s3;
    logic [5:0]                    line_q;
    logic [1:0]                    refsel_s1;
    logic [1:0]                    refsel_s2;
    logic [1:0]                    refsel_s3;
    link_setup_pkg::neg_state_type neg;
    logic                          link_was_up;
    logic                          aneg_active;
    logic [1:0]                    speed;
    logic                          duplex_full;
    logic                          parallel;
    logic                          crossed;
    logic                          pol_inv_a;
    logic                          pol_inv_b;
    logic                          lpi;
    logic                          tx10_low;
    logic [1:0]                    clk_mode;
    logic                          osc_on;
    logic                          pd_searching;
    logic [1:0]                    pd_status;
    logic                          pd_irq;
    logic                          link_status;
    logic                          link_fail;
  } top_state_type;

  top_state_type s_reg;
  top_state_type s_next;

  link_setup_pkg::ctrl_type  ctrl;
  link_setup_pkg::line_type  line;
  link_setup_pkg::xover_type xo;
  link_setup_pkg::pd_type    pd;
  logic                      auto_ok;

  // Speed code from the two forced-speed bits
  function automatic logic [1:0] forced_speed(input logic msb, input logic lsb);
    forced_speed = {lsb, msb};
  endfunction

  // Accept a pin change once second and third stages agree
  function automatic logic [5:0] agree6(input logic [5:0] a, input logic [5:0] b,
                                        input logic [5:0] q);
    agree6 = (a & b) | (q & (a | b));
  endfunction

  assign ctrl.aneg_en           = ANEG_EN;
  assign ctrl.speed_lsb         = SPEED_LSB;
  assign ctrl.speed_msb         = SPEED_MSB;
  assign ctrl.full_duplex       = FULL_DUPLEX;
  assign ctrl.xover_en          = XOVER_EN;
  assign ctrl.pol_en            = POL_EN;
  assign ctrl.xover_forced_ok_n = XOVER_FORCED_OK_N;
  assign ctrl.xover_force       = XOVER_FORCE;
  assign ctrl.tx10_reduced      = TX10_REDUCED;
  assign ctrl.pd_en             = PD_EN;

  assign line = s_reg.line_q;

  // Auto crossover when enabled: with negotiation, or forced speed when allowed
  assign auto_ok = ctrl.xover_en &&
                   (ctrl.aneg_en || !ctrl.xover_forced_ok_n);

  // --------------------------------------------------------------------
  // Sub-blocks
  // --------------------------------------------------------------------
  pair_crossover #(
    .DWELL_CYC (XOVER_DWELL_CYC)
  ) u_xover (
    .clk          (CLK),
    .rst          (SYS_RST),
    .auto_allowed (auto_ok),
    .force_mode   (ctrl.xover_force),
    .pol_en       (ctrl.pol_en),
    .line         (line),
    .result       (xo)
  );

  pd_detect #(
    .LIMIT_CYC (PD_LIMIT_CYC)
  ) u_pd (
    .clk       (CLK),
    .rst       (SYS_RST),
    .enable    (ctrl.pd_en),
    .flp_echo  (line.flp_echo),
    .link_fail (s_reg.link_fail),
    .irq_read  (PD_IRQ_READ),
    .pd        (pd)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.line_s1 = {LINE_ENERGY, LINE_FLP_SEEN, LINE_FLP_ECHO,
                      LINE_LINK_GOOD, LINE_POL_BAD_A, LINE_POL_BAD_B};
    s_next.line_s2 = s_reg.line_s1;
    s_next.line_s3 = s_reg.line_s2;
    s_next.line_q  = agree6(s_reg.line_s2, s_reg.line_s3, s_reg.line_q);
    s_next.refsel_s1 = REF_CLOCK_MODE_SELECT;
    s_next.refsel_s2 = s_reg.refsel_s1;
    s_next.refsel_s3 = s_reg.refsel_s2;
    if (s_reg.refsel_s2 == s_reg.refsel_s3) begin
      s_next.clk_mode = s_reg.refsel_s3;
      s_next.osc_on   = (s_reg.refsel_s3 == link_setup_pkg::CLK_25_XTAL);
    end
    s_next.link_fail = 1'b0;

    // Negotiation waits while powered-device search holds the line
    case (s_reg.neg)
      link_setup_pkg::NEG_IDLE: begin
        s_next.aneg_active = 1'b0;
        if (ctrl.aneg_en && !pd.active) begin
          s_next.neg         = link_setup_pkg::NEG_RUN;
          s_next.aneg_active = 1'b1;
        end else if (!ctrl.aneg_en && line.link_good) begin
          s_next.neg = link_setup_pkg::NEG_LINK;
        end
      end
      link_setup_pkg::NEG_RUN: begin
        s_next.aneg_active = 1'b1;
        if (!ctrl.aneg_en || pd.active) begin
          s_next.neg         = link_setup_pkg::NEG_IDLE;
          s_next.aneg_active = 1'b0;
        end else if (line.link_good) begin
          s_next.neg = link_setup_pkg::NEG_LINK;
          if (!line.flp_seen) begin
            // Partner idles without pulses: fall back to speed sensing
            s_next.parallel    = 1'b1;
            s_next.speed       = line.energy ? `SPEED_100 : `SPEED_10;
            s_next.duplex_full = 1'b0;
          end else begin
            s_next.parallel    = 1'b0;
            s_next.speed       = `SPEED_100;
            s_next.duplex_full = 1'b1;
          end
        end
      end
      link_setup_pkg::NEG_LINK: begin
        if (!line.link_good) begin
          s_next.neg         = link_setup_pkg::NEG_IDLE;
          s_next.aneg_active = 1'b0;
          s_next.link_fail   = s_reg.link_was_up;
        end
      end
      default: begin
        s_next.neg = link_setup_pkg::NEG_IDLE;
      end
    endcase
    if (!ctrl.aneg_en) begin
      s_next.aneg_active = 1'b0;
      s_next.speed       = forced_speed(ctrl.speed_msb, ctrl.speed_lsb);
      s_next.duplex_full = ctrl.full_duplex;
      s_next.parallel    = 1'b0;
    end

    s_next.link_was_up = (s_reg.neg == link_setup_pkg::NEG_LINK);
    s_next.link_status = (s_reg.neg == link_setup_pkg::NEG_LINK) && line.link_good;

    s_next.crossed   = xo.crossed;
    s_next.pol_inv_a = xo.pol_inv_a;
    s_next.pol_inv_b = xo.pol_inv_b;

    s_next.lpi = s_reg.link_status && (s_reg.speed == `SPEED_100) && TX_IDLE;
    s_next.tx10_low = ctrl.tx10_reduced && (s_reg.speed == `SPEED_10);

    s_next.pd_searching = pd.active && (pd.state == link_setup_pkg::PD_SEARCH);
    s_next.pd_status    = pd.det_status;
    s_next.pd_irq       = pd.pd_irq;
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ANEG_ACTIVE       = s_reg.aneg_active;
  assign SPEED             = s_reg.speed;
  assign DUPLEX_FULL       = s_reg.duplex_full;
  assign PARALLEL_DETECTED = s_reg.parallel;
  assign CROSSED           = s_reg.crossed;
  assign POL_INV_A         = s_reg.pol_inv_a;
  assign POL_INV_B         = s_reg.pol_inv_b;
  assign LPI_ACTIVE        = s_reg.lpi;
  assign TX10_LOW_AMP      = s_reg.tx10_low;
  assign CLK_MODE          = s_reg.clk_mode;
  assign OSC_ON            = s_reg.osc_on;
  assign PD_SEARCHING      = s_reg.pd_searching;
  assign PD_STATUS         = s_reg.pd_status;
  assign PD_IRQ            = s_reg.pd_irq;
  assign LINK_STATUS       = s_reg.link_status;

endmodule

// ==== logic/link_setup_consts.svh ====
// Constants of the link-setup and powered-device detection block.
// Assumes inclusion by the package and the modules of this block only.
//
// Behaviour
// - Auto-negotiation runs only while its enable bit set
// - Forced speed and duplex from control bits
// - Parallel detection picks speed without partner negotiation
// - Crossover and polarity correction enabled at reset
// - Crossover and polarity results shown as status
// - Forced-speed crossover when bit clear, negotiation off
// - Crossover resolves straight or swapped pair wiring
// - Force field: 10 straight, 11 crossed, 00 automatic
// - Low power idle used at 100 Mbps
// - Reduced-amplitude 10 Mbps transmitter when bit set
// - Strap inputs choose reference clock mode
// - Searching sends pulse pattern, status reads 00
// - Looped-back pulses set status 01
// - Detection sets sticky interrupt, read clears it
// - Timeout without loopback sets status 10
// - Status 10 ends detection, negotiation resumes
// - Link status set on link, cleared on failure
// - Link failure returns to detection mode
`ifndef LINK_SETUP_CONSTS_SVH
`define LINK_SETUP_CONSTS_SVH

// ----------------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------------
`define PD_STAT_SEARCH   2'h0
`define PD_STAT_FOUND    2'h1
`define PD_STAT_TIMEOUT  2'h2
`define XOVER_FORCE_STR  2'h2
`define XOVER_FORCE_CRS  2'h3
`define XOVER_FORCE_AUTO 2'h0
`define SPEED_10         2'h0
`define SPEED_100        2'h1

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define XOVER_EN_RST     1'h1
`define POL_EN_RST       1'h1
`define CLK_PERIOD_NS    25
`define PD_LIMIT_US      100000
`define PD_LIMIT_CYC     ((`PD_LIMIT_US * 1000) / `CLK_PERIOD_NS)
`define XOVER_DWELL_US   100
`define XOVER_DWELL_CYC  ((`XOVER_DWELL_US * 1000) / `CLK_PERIOD_NS)

`endif

// ==== logic/link_setup_pkg.sv ====
// Types of the link-setup block.
// Assumes the constants header sits beside it.
`include "link_setup_consts.svh"

package link_setup_pkg;

  // --------------------------------------------------------------------
  // Enumerations
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PD_OFF    = 2'h0,
    PD_SEARCH = 2'h1,
    PD_FOUND  = 2'h2
  } pd_state_type;

  typedef enum logic [1:0] {
    NEG_IDLE  = 2'h0,
    NEG_RUN   = 2'h1,
    NEG_LINK  = 2'h2
  } neg_state_type;

  typedef enum logic [1:0] {
    CLK_25_XTAL = 2'h0,
    CLK_25_EXT  = 2'h1,
    CLK_50_EXT  = 2'h2,
    CLK_125_EXT = 2'h3
  } clk_mode_type;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic       aneg_en;
    logic       speed_lsb;
    logic       speed_msb;
    logic       full_duplex;
    logic       xover_en;
    logic       pol_en;
    logic       xover_forced_ok_n;
    logic [1:0] xover_force;
    logic       tx10_reduced;
    logic       pd_en;
  } ctrl_type;

  typedef struct packed {
    logic       energy;
    logic       flp_seen;
    logic       flp_echo;
    logic       link_good;
    logic       pol_bad_a;
    logic       pol_bad_b;
  } line_type;

  typedef struct packed {
    logic       crossed;
    logic       pol_inv_a;
    logic       pol_inv_b;
  } xover_type;

  typedef struct packed {
    logic       active;
    logic [1:0] det_status;
    logic       pd_irq;
    logic [$clog2(`PD_LIMIT_CYC + 1)-1:0] cnt;
    pd_state_type state;
  } pd_type;

  typedef struct packed {
    logic [1:0] cnt_sel;
    logic       crossed;
    logic       pol_inv_a;
    logic       pol_inv_b;
    logic [$clog2(`XOVER_DWELL_CYC + 1)-1:0] cnt;
  } xo_state_type;

endpackage

// ==== logic/pair_crossover.sv ====
// Crossover and polarity resolution of the two medium pairs.
// Assumes synchronised line indications on the same clock.
`timescale 1ns/1ps
`include "link_setup_consts.svh"

module pair_crossover #(
  parameter int DWELL_CYC = `XOVER_DWELL_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   auto_allowed,
  input  wire logic [1:0]             force_mode,
  input  wire logic                   pol_en,
  input  wire link_setup_pkg::line_type line,
  output link_setup_pkg::xover_type   result
);

  initial begin
    if (DWELL_CYC < 1 || DWELL_CYC > `XOVER_DWELL_CYC) $error("pair_crossover: bad DWELL_CYC");
  end

  link_setup_pkg::xo_state_type st_reg;
  link_setup_pkg::xo_state_type st_next;

  always_comb begin
    st_next = st_reg;
    case (force_mode)
      `XOVER_FORCE_STR: begin
        st_next.crossed = 1'b0;
        st_next.cnt     = '0;
      end
      `XOVER_FORCE_CRS: begin
        st_next.crossed = 1'b1;
        st_next.cnt     = '0;
      end
      default: begin
        // Toggle wiring guess until energy or a good link arrives on the receive pair
        if (auto_allowed && !line.energy && !line.link_good) begin
          if (st_reg.cnt == DWELL_CYC[$bits(st_reg.cnt)-1:0] - 1'b1) begin
            st_next.cnt     = '0;
            st_next.crossed = ~st_reg.crossed;
          end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
          end
        end else begin
          st_next.cnt = '0;
        end
      end
    endcase
    if (pol_en && !line.link_good) begin
      st_next.pol_inv_a = line.pol_bad_a;
      st_next.pol_inv_b = line.pol_bad_b;
    end else if (!pol_en) begin
      st_next.pol_inv_a = 1'b0;
      st_next.pol_inv_b = 1'b0;
    end
    st_next.cnt_sel = force_mode;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result.crossed   = st_reg.crossed;
  assign result.pol_inv_a = st_reg.pol_inv_a;
  assign result.pol_inv_b = st_reg.pol_inv_b;

endmodule

// ==== logic/pd_detect.sv ====
// Legacy powered-device detection sequencer.
// Assumes line flags are synchronised to clk before they arrive.
`timescale 1ns/1ps
`include "link_setup_consts.svh"

module pd_detect #(
  parameter int LIMIT_CYC = `PD_LIMIT_CYC
) (
  input  wire logic           clk,
  input  wire logic           rst,
  input  wire logic           enable,
  input  wire logic           flp_echo,
  input  wire logic           link_fail,
  input  wire logic           irq_read,
  output link_setup_pkg::pd_type pd
);

  localparam int CW = $clog2(`PD_LIMIT_CYC + 1);

  initial begin
    if (LIMIT_CYC < 1 || LIMIT_CYC > `PD_LIMIT_CYC)
      $error("pd_detect: LIMIT_CYC out of range");
  end

  link_setup_pkg::pd_type pd_reg;
  link_setup_pkg::pd_type pd_next;

  always_comb begin
    pd_next = pd_reg;
    case (pd_reg.state)
      link_setup_pkg::PD_OFF: begin
        pd_next.active = 1'b0;
        pd_next.cnt    = '0;
        if (enable && (pd_reg.det_status != `PD_STAT_TIMEOUT || link_fail)) begin
          pd_next.state      = link_setup_pkg::PD_SEARCH;
          pd_next.det_status = `PD_STAT_SEARCH;
          pd_next.active     = 1'b1;
        end
      end
      link_setup_pkg::PD_SEARCH: begin
        pd_next.active = 1'b1;
        if (!enable) begin
          pd_next.state  = link_setup_pkg::PD_OFF;
          pd_next.active = 1'b0;
        end else if (flp_echo) begin
          pd_next.state      = link_setup_pkg::PD_FOUND;
          pd_next.det_status = `PD_STAT_FOUND;
        end else if (pd_reg.cnt == LIMIT_CYC[CW-1:0] - 1'b1) begin
          pd_next.state      = link_setup_pkg::PD_OFF;
          pd_next.det_status = `PD_STAT_TIMEOUT;
          pd_next.active     = 1'b0;
        end else begin
          pd_next.cnt = pd_reg.cnt + 1'b1;
        end
      end
      link_setup_pkg::PD_FOUND: begin
        pd_next.active = 1'b1;
        if (!enable) begin
          pd_next.state = link_setup_pkg::PD_OFF;
        end
      end
      default: begin
        pd_next.state = link_setup_pkg::PD_OFF;
      end
    endcase
    // Set beats the clearing read
    if (irq_read) pd_next.pd_irq = 1'b0;
    if (pd_reg.state == link_setup_pkg::PD_SEARCH && enable && flp_echo)
      pd_next.pd_irq = 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pd_reg <= '0;
    end else begin
      pd_reg <= pd_next;
    end
  end

  assign pd = pd_reg;

endmodule

// ==== sim/link_setup_props.sv ====
// Checker for the link-setup top: control-to-status relations.
// Assumes a bind to link_setup with the same detection limit.
`timescale 1ns/1ps

module link_setup_props #(
  parameter int PD_LIMIT_CYC = 50
) (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       ANEG_EN,
  input wire logic       SPEED_LSB,
  input wire logic       SPEED_MSB,
  input wire logic       FULL_DUPLEX,
  input wire logic [1:0] XOVER_FORCE,
  input wire logic       TX10_REDUCED,
  input wire logic       PD_EN,
  input wire logic       PD_IRQ_READ,
  input wire logic       TX_IDLE,
  input wire logic [1:0] REF_CLOCK_MODE_SELECT,
  input wire logic       LINE_FLP_ECHO,
  input wire logic       LINE_LINK_GOOD,
  input wire logic       ANEG_ACTIVE,
  input wire logic [1:0] SPEED,
  input wire logic       DUPLEX_FULL,
  input wire logic       CROSSED,
  input wire logic       LPI_ACTIVE,
  input wire logic       TX10_LOW_AMP,
  input wire logic [1:0] CLK_MODE,
  input wire logic       OSC_ON,
  input wire logic       PD_SEARCHING,
  input wire logic [1:0] PD_STATUS,
  input wire logic       PD_IRQ,
  input wire logic       LINK_STATUS
);
  logic [31:0] wait_reg;

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // Cycles spent searching with no loopback seen
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wait_reg <= 32'h0;
    end else if (PD_SEARCHING && PD_STATUS == 2'h0 && !LINE_FLP_ECHO) begin
      wait_reg <= wait_reg + 32'h1;
    end else begin
      wait_reg <= 32'h0;
    end
  end

  aneg_off_a: assert property (!ANEG_EN [*3] |-> !ANEG_ACTIVE)
    else $error("negotiation active while disabled");
  forced_speed_a: assert property (
    (!ANEG_EN && !PD_EN && $stable({SPEED_LSB, SPEED_MSB, FULL_DUPLEX})) [*4]
    |-> SPEED == {SPEED_LSB, SPEED_MSB} && DUPLEX_FULL == FULL_DUPLEX)
    else $error("forced speed or duplex wrong");
  force_straight_a: assert property (XOVER_FORCE == 2'h2 [*8] |-> !CROSSED)
    else $error("straight force ignored");
  force_crossed_a: assert property (XOVER_FORCE == 2'h3 [*8] |-> CROSSED)
    else $error("crossed force ignored");
  low_amp_a: assert property ((TX10_REDUCED && SPEED == 2'h0) [*3] |-> TX10_LOW_AMP)
    else $error("reduced amplitude not taken");
  irq_set_a: assert property ($rose(PD_STATUS == 2'h1) |-> ##[0:2] PD_IRQ)
    else $error("no interrupt on detection");
  irq_clear_a: assert property (PD_IRQ && PD_IRQ_READ |=> ##[0:1] !PD_IRQ)
    else $error("interrupt not cleared by read");
  pd_bound_a: assert property (wait_reg <= PD_LIMIT_CYC + 8)
    else $error("search outlived its limit");
  timeout_end_a: assert property (PD_STATUS == 2'h2 |-> !PD_SEARCHING)
    else $error("search kept after timeout");
  link_down_a: assert property (!LINE_LINK_GOOD [*8] |-> !LINK_STATUS)
    else $error("link status without link");
  lpi_idle_a: assert property (!TX_IDLE [*3] |-> !LPI_ACTIVE)
    else $error("low power idle while busy");
  clk_mode_a: assert property ($stable(REF_CLOCK_MODE_SELECT) [*8]
    |-> CLK_MODE == REF_CLOCK_MODE_SELECT && OSC_ON == (REF_CLOCK_MODE_SELECT == 2'h0))
    else $error("clock mode mismatch");

  cover property (PD_STATUS == 2'h1);
  cover property (PD_STATUS == 2'h2);
  cover property (LPI_ACTIVE);
endmodule

bind link_setup link_setup_props #(.PD_LIMIT_CYC(PD_LIMIT_CYC)) link_setup_props_i (.*);

// ==== sim/cable_peer.sv ====
// Cable link partner: loops pulses back while unpowered, makes link.
// Assumes the bench steers its behaviour through plain inputs.
`timescale 1ns/1ps

module cable_peer (
  input  wire logic clk,
  input  wire logic searching,
  input  wire logic unpowered,
  input  wire logic link_up,
  input  wire logic negotiates,
  input  wire logic fast,
  input  wire logic pol_swap,
  output logic      energy,
  output logic      flp_seen,
  output logic      flp_echo,
  output logic      link_good,
  output logic      pol_bad_a
);
  // Unpowered peer returns the pulse pattern
  always @(posedge clk) begin
    flp_echo <= #1 unpowered && searching;
  end

  assign energy    = link_up && fast;
  assign flp_seen  = link_up && negotiates;
  assign link_good = link_up;
  assign pol_bad_a = pol_swap;
endmodule

// ==== sim/link_setup_test.sv ====
// Self-checking bench for the link-setup block.
// Assumes the design under logic/ and the cable peer beside this file.
`timescale 1ns/1ps

module link_setup_test;
  localparam int LIMIT = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  link_setup_pkg::ctrl_type ctrl;
  logic unpowered, link_up, negotiates, fast, pol_swap, tx_idle, irq_read;
  logic [1:0] strap, speed, clk_mode, pd_status;
  logic aneg_act, dup, par_det, crossed, pol_a, pol_b, lpi, low_amp, osc_on;
  logic pd_search, pd_irq, link, energy, flp_seen, flp_echo, link_good, pol_bad_a;
  int fails = 0;
  int checks = 0;

  initial begin
    forever #12.5 clk = ~clk;
  end

  link_setup #(.PD_LIMIT_CYC(LIMIT), .XOVER_DWELL_CYC(8)) link_setup_i (
    .CLK(clk), .SYS_RST(rst), .ANEG_EN(ctrl.aneg_en), .SPEED_LSB(ctrl.speed_lsb),
    .SPEED_MSB(ctrl.speed_msb), .FULL_DUPLEX(ctrl.full_duplex), .XOVER_EN(ctrl.xover_en),
    .POL_EN(ctrl.pol_en), .XOVER_FORCED_OK_N(ctrl.xover_forced_ok_n),
    .XOVER_FORCE(ctrl.xover_force), .TX10_REDUCED(ctrl.tx10_reduced), .PD_EN(ctrl.pd_en),
    .PD_IRQ_READ(irq_read), .TX_IDLE(tx_idle), .REF_CLOCK_MODE_SELECT(strap),
    .LINE_ENERGY(energy), .LINE_FLP_SEEN(flp_seen), .LINE_FLP_ECHO(flp_echo),
    .LINE_LINK_GOOD(link_good), .LINE_POL_BAD_A(pol_bad_a), .LINE_POL_BAD_B(pol_bad_a),
    .ANEG_ACTIVE(aneg_act), .SPEED(speed), .DUPLEX_FULL(dup), .PARALLEL_DETECTED(par_det),
    .CROSSED(crossed), .POL_INV_A(pol_a), .POL_INV_B(pol_b), .LPI_ACTIVE(lpi),
    .TX10_LOW_AMP(low_amp), .CLK_MODE(clk_mode), .OSC_ON(osc_on),
    .PD_SEARCHING(pd_search), .PD_STATUS(pd_status), .PD_IRQ(pd_irq), .LINK_STATUS(link));

  cable_peer cable_peer_i (
    .clk(clk), .searching(pd_search), .unpowered(unpowered), .link_up(link_up),
    .negotiates(negotiates), .fast(fast), .pol_swap(pol_swap), .energy(energy),
    .flp_seen(flp_seen), .flp_echo(flp_echo), .link_good(link_good), .pol_bad_a(pol_bad_a));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic cmp(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_clock();
    for (int m = 0; m < 4; m++) begin
      strap = m[1:0];
      cyc(12);
      cmp(clk_mode, m[1:0], "clock mode");
      cmp({1'b0, osc_on}, {1'b0, m == 0}, "oscillator");
    end
    $display("test clock done");
  endtask

  task automatic t_forced();
    ctrl.aneg_en = 1'b0;
    for (int m = 0; m < 4; m++) begin
      ctrl.speed_msb = m[0];
      ctrl.full_duplex = m[1];
      cyc(4);
      cmp(speed, {1'b0, m[0]}, "forced speed");
      cmp({1'b0, dup}, {1'b0, m[1]}, "forced duplex");
      cmp({1'b0, aneg_act}, 2'h0, "negotiation off");
    end
    ctrl.speed_msb = 1'b0;
    ctrl.tx10_reduced = 1'b1;
    cyc(5);
    cmp({1'b0, low_amp}, 2'h1, "low amplitude");
    ctrl.tx10_reduced = 1'b0;
    $display("test forced done");
  endtask

  task automatic t_xover();
    ctrl.xover_force = 2'h3;
    cyc(10);
    cmp({1'b0, crossed}, 2'h1, "forced crossed");
    ctrl.xover_force = 2'h2;
    cyc(10);
    cmp({1'b0, crossed}, 2'h0, "forced straight");
    ctrl.xover_force = 2'h0;
    pol_swap = 1'b1;
    cyc(20);
    cmp({pol_b, pol_a}, 2'h3, "polarity fixed");
    ctrl.pol_en = 1'b0;
    cyc(20);
    cmp({pol_b, pol_a}, 2'h0, "polarity off");
    ctrl.pol_en = 1'b1;
    pol_swap = 1'b0;
    ctrl.xover_forced_ok_n = 1'b0;
    cyc(12);
    cmp({1'b0, crossed}, 2'h1, "auto crossover");
    $display("test crossover done");
  endtask

  task automatic t_parallel();
    int n;
    ctrl.aneg_en = 1'b1;
    link_up = 1'b1;
    fast = 1'b1;
    for (n = 0; n < 40 && link !== 1'b1; n++) cyc(1);
    cmp({1'b0, link}, 2'h1, "link up");
    cmp({1'b0, par_det}, 2'h1, "parallel detect");
    cmp(speed, 2'h1, "parallel speed");
    tx_idle = 1'b1;
    cyc(4);
    cmp({1'b0, lpi}, 2'h1, "low power idle");
    tx_idle = 1'b0;
    link_up = 1'b0;
    for (n = 0; n < 40 && link !== 1'b0; n++) cyc(1);
    cmp({1'b0, link}, 2'h0, "link down");
    $display("test parallel done");
  endtask

  task automatic t_pd_found();
    int n;
    unpowered = 1'b1;
    ctrl.pd_en = 1'b1;
    cyc(2);
    cmp({1'b0, pd_search}, 2'h1, "searching");
    cmp(pd_status, 2'h0, "search code");
    for (n = 0; n < 40 && pd_status !== 2'h1; n++) cyc(1);
    cyc(1);
    cmp(pd_status, 2'h1, "device found");
    cmp({1'b0, pd_irq}, 2'h1, "irq set");
    cmp({1'b0, aneg_act}, 2'h0, "negotiation held");
    irq_read = 1'b1;
    cyc(1);
    irq_read = 1'b0;
    cyc(1);
    cmp({1'b0, pd_irq}, 2'h0, "irq cleared");
    unpowered = 1'b0;
    ctrl.pd_en = 1'b0;
    cyc(4);
    $display("test detect done");
  endtask

  task automatic t_pd_timeout();
    int n;
    ctrl.pd_en = 1'b1;
    for (n = 0; n < 200 && pd_status !== 2'h2; n++) cyc(1);
    cmp({1'b0, n >= LIMIT && n <= LIMIT + 8}, 2'h1, "time limit");
    cmp({1'b0, pd_search}, 2'h0, "search ended");
    cyc(3);
    cmp({1'b0, aneg_act}, 2'h1, "negotiating");
    negotiates = 1'b1;
    link_up = 1'b1;
    for (n = 0; n < 40 && link !== 1'b1; n++) cyc(1);
    cmp({1'b0, link}, 2'h1, "negotiated link");
    link_up = 1'b0;
    negotiates = 1'b0;
    for (n = 0; n < 40 && pd_search !== 1'b1; n++) cyc(1);
    cmp({1'b0, link}, 2'h0, "link failed");
    cmp({1'b0, pd_search}, 2'h1, "search again");
    cmp(pd_status, 2'h0, "search code again");
    ctrl.pd_en = 1'b0;
    cyc(4);
    $display("test timeout done");
  endtask

  initial begin
    ctrl = '{aneg_en: 1'b1, xover_en: 1'b1, pol_en: 1'b1, xover_forced_ok_n: 1'b1, default: '0};
    {unpowered, link_up, negotiates, fast, pol_swap, tx_idle, irq_read} = '0;
    strap = 2'h0;
    cyc(20);
    rst = 1'b0;
    t_clock();
    t_forced();
    t_xover();
    t_parallel();
    t_pd_found();
    t_pd_timeout();
    tally_and_finish();
  end

  initial begin
    #(4000 * 25);
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
